/* File: rtl/tpc_eval_tick.sv */
// evaluation strobe divider
// assumes one free-running clock
`timescale 1ns/10ps
`default_nettype none
module tpc_eval_tick
#(
   parameter int CYCLES = 100
)
(
   input  wire logic CLOCK,
   input  wire logic RESET_N,
   output logic      tick
);
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic        tick_nxt;

   always_comb
   begin
      tick_nxt = (cnt_r == 16'(CYCLES - 1));
      cnt_nxt  = tick_nxt ? 16'h0000 : cnt_r + 16'h0001;
   end

   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         cnt_r <= 16'h0000;
         tick  <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         tick  <= tick_nxt;
      end
   end
endmodule // tpc_eval_tick
`default_nettype wire

/* File: rtl/tpc_pkg.sv */
// package for the thermistor profile configuration registers
// assumes an 8-bit register port from the serial interface front end
`default_nettype none
package tpc_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] TPC_ADDR_CTRL_A  = 8'h1A;
   localparam logic [7:0] TPC_ADDR_CTRL_B  = 8'h1B;
   localparam logic [7:0] TPC_RST_CTRL_A   = 8'h3D;
   localparam logic [7:0] TPC_RST_CTRL_B   = 8'h25;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int TPC_OVR_BIT      = 7;
   localparam int TPC_OTG_HOT_LSB  = 5;
   localparam int TPC_OTG_COLD_BIT = 4;
   localparam int TPC_WARM_I_LSB   = 2;
   localparam int TPC_COOL_I_LSB   = 0;
   localparam int TPC_COLD_SEL_LSB = 5;
   localparam int TPC_HOT_SEL_LSB  = 2;
   localparam int TPC_WARM_V_LSB   = 0;
   // ---------------------------------------------------------------
   // codes
   // ---------------------------------------------------------------
   localparam logic [1:0] TPC_HOT_DISABLE = 2'h3;
   localparam logic [1:0] TPC_I_SUSPEND   = 2'h0;
   localparam logic [1:0] TPC_I_PCT20     = 2'h1;
   localparam logic [1:0] TPC_I_PCT40     = 2'h2;
   localparam logic [1:0] TPC_I_FULL      = 2'h3;
   localparam logic [1:0] TPC_V_UNCHANGED = 2'h3;
   // zone evaluation period in cycles of the 10 MHz clock
   localparam int TPC_EVAL_PERIOD_US   = 10;
   localparam int TPC_CLOCK_MHZ        = 10;
   localparam int TPC_EVAL_CYCLES      = TPC_EVAL_PERIOD_US * TPC_CLOCK_MHZ;
   // temperature zones as seen by the comparators
   typedef enum logic [2:0] {
      TPC_ZONE_COLD, TPC_ZONE_COOL, TPC_ZONE_NORMAL, TPC_ZONE_WARM, TPC_ZONE_HOT
   } tpc_zone_t;
endpackage : tpc_pkg
`default_nettype wire

/* File: rtl/tpc_regs.sv */
// thermistor profile configuration registers and decoded settings
// assumes the serial front end gives a one-cycle write strobe with address and data,
// and that the comparator bank reports the raw temperature zone
// Functional notes
// - with the override bit set the zone is taken as normal, charging and otg are allowed.
// - the override bit resets to 0 on power reset, register reset and watchdog expiry.
// - otg hot code picks 55, 60 or 65 degrees, code 3 disables the hot check, default 1.
// - otg cold bit picks -20 (0) or -10 (1) degrees, default 1.
// - warm current code: suspend, 20%, 40% or unchanged, default unchanged.
// - cool current code uses the same encoding with default 20%.
// - cold-side comparator select is a 3-bit code, default 1.
// - hot-side comparator select is a 3-bit code, default 1.
// - warm voltage code lowers the target by 300, 200 or 100 mV, or leaves it, default 200.
// - control a sits at 1Ah, resets to 3Dh, other fields restored by power reset and register reset.
// - control b sits at 1Bh, resets to 25h, restored by power reset and register reset.
`timescale 1ns/10ps
`default_nettype none
module tpc_regs
   import tpc_pkg::*;
#(
   parameter int EVAL_CYCLES = tpc_pkg::TPC_EVAL_CYCLES
)
(
   input  wire logic                CLOCK,
   input  wire logic                RESET_N,
   input  wire logic                REG_RESET,
   input  wire logic                WATCHDOG_EXPIRED,
   input  wire logic                WR_EN,
   input  wire logic [7:0]          ADDR,
   input  wire logic [7:0]          WR_DATA,
   output logic      [7:0]          RD_DATA,
   input  wire tpc_pkg::tpc_zone_t  RAW_ZONE,
   output tpc_pkg::tpc_zone_t       THERMISTOR_CONDITION,
   output logic                     CHARGE_ALLOW,
   output logic                     OTG_ALLOW,
   output logic      [1:0]          CHARGE_CURRENT_SEL,
   output logic      [1:0]          CHARGE_VOLTAGE_SEL,
   output logic      [1:0]          OTG_HOT_LIMIT,
   output logic                     OTG_COLD_LIMIT,
   output logic      [2:0]          COLD_SIDE_COMPARATOR_SEL,
   output logic      [2:0]          HOT_SIDE_COMPARATOR_SEL
);
   import tpc_pkg::*;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0] ctrl_a_r;
   logic [7:0] ctrl_a_nxt;
   logic [7:0] ctrl_b_r;
   logic [7:0] ctrl_b_nxt;
   logic [7:0] rd_nxt;
   logic       eval_tick;

   always_comb
   begin
      ctrl_a_nxt = ctrl_a_r;
      ctrl_b_nxt = ctrl_b_r;
      if (REG_RESET)
      begin
         ctrl_a_nxt = TPC_RST_CTRL_A;
         ctrl_b_nxt = TPC_RST_CTRL_B;
      end
      else
      begin
         if (WR_EN && ADDR == TPC_ADDR_CTRL_A)
            ctrl_a_nxt = WR_DATA;
         if (WR_EN && ADDR == TPC_ADDR_CTRL_B)
            ctrl_b_nxt = WR_DATA;
         // watchdog only touches the override bit
         if (WATCHDOG_EXPIRED)
            ctrl_a_nxt[TPC_OVR_BIT] = TPC_RST_CTRL_A[TPC_OVR_BIT];
      end
      unique case (ADDR)
         TPC_ADDR_CTRL_A: rd_nxt = ctrl_a_nxt;
         TPC_ADDR_CTRL_B: rd_nxt = ctrl_b_nxt;
         default:         rd_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         ctrl_a_r <= TPC_RST_CTRL_A;
         ctrl_b_r <= TPC_RST_CTRL_B;
         RD_DATA  <= 8'h00;
      end
      else
      begin
         ctrl_a_r <= ctrl_a_nxt;
         ctrl_b_r <= ctrl_b_nxt;
         RD_DATA  <= rd_nxt;
      end
   end

   // ---------------------------------------------------------------
   // zone evaluation
   // ---------------------------------------------------------------
   // settings are sampled only on the tick, so a pair of writes glitches the outputs only if a tick falls between them
   tpc_eval_tick #(.CYCLES(EVAL_CYCLES)) u_tick
   (
      .CLOCK   (CLOCK),
      .RESET_N (RESET_N),
      .tick    (eval_tick)
   );

   // ---------------------------------------------------------------
   // field decode helpers
   // ---------------------------------------------------------------
   // every setting is a slice of one of the two registers; the two picks keep
   // the positions in the package and nowhere else
   function automatic logic [1:0] field2(input logic [7:0] reg_val, input int lsb);
      return reg_val[lsb +: 2];
   endfunction

   function automatic logic [2:0] field3(input logic [7:0] reg_val, input int lsb);
      return reg_val[lsb +: 3];
   endfunction

   // a zone current code of zero suspends charging in that zone
   function automatic logic charge_permitted(input logic [1:0] code);
      return (code != TPC_I_SUSPEND);
   endfunction

   tpc_zone_t  zone_eval;
   logic       chg_eval;
   logic       otg_eval;
   logic [1:0] isel_eval;
   logic [1:0] vsel_eval;
   logic [1:0] hot_f;
   logic [1:0] warm_i;
   logic [1:0] cool_i;
   tpc_zone_t  cond_nxt;
   logic       chg_nxt;
   logic       otg_nxt;
   logic [1:0] isel_nxt;
   logic [1:0] vsel_nxt;
   logic [1:0] hot_lim_nxt;
   logic       cold_lim_nxt;
   logic [2:0] cold_sel_nxt;
   logic [2:0] hot_sel_nxt;

   always_comb
   begin
      hot_f     = field2(ctrl_a_r, TPC_OTG_HOT_LSB);
      warm_i    = field2(ctrl_a_r, TPC_WARM_I_LSB);
      cool_i    = field2(ctrl_a_r, TPC_COOL_I_LSB);
      zone_eval = ctrl_a_r[TPC_OVR_BIT] ? TPC_ZONE_NORMAL : RAW_ZONE;
      chg_eval  = 1'b1;
      otg_eval  = 1'b1;
      isel_eval = TPC_I_FULL;
      vsel_eval = TPC_V_UNCHANGED;
      unique case (zone_eval)
         TPC_ZONE_COLD:
         begin
            chg_eval  = 1'b0;
            otg_eval  = 1'b0;
            isel_eval = TPC_I_SUSPEND;
         end
         TPC_ZONE_COOL:
         begin
            isel_eval = cool_i;
            chg_eval  = charge_permitted(cool_i);
         end
         TPC_ZONE_WARM:
         begin
            isel_eval = warm_i;
            chg_eval  = charge_permitted(warm_i);
            vsel_eval = field2(ctrl_b_r, TPC_WARM_V_LSB);
         end
         TPC_ZONE_HOT:
         begin
            chg_eval  = 1'b0;
            isel_eval = TPC_I_SUSPEND;
            otg_eval  = (hot_f == TPC_HOT_DISABLE);
         end
         default:
         begin
            // normal zone, and any unused comparator code, charges as programmed
            chg_eval  = 1'b1;
         end
      endcase
      // between ticks everything holds, so a half-written profile reaches the pins only if a tick falls between its writes
      cond_nxt     = THERMISTOR_CONDITION;
      chg_nxt      = CHARGE_ALLOW;
      otg_nxt      = OTG_ALLOW;
      isel_nxt     = CHARGE_CURRENT_SEL;
      vsel_nxt     = CHARGE_VOLTAGE_SEL;
      hot_lim_nxt  = OTG_HOT_LIMIT;
      cold_lim_nxt = OTG_COLD_LIMIT;
      cold_sel_nxt = COLD_SIDE_COMPARATOR_SEL;
      hot_sel_nxt  = HOT_SIDE_COMPARATOR_SEL;
      if (eval_tick)
      begin
         cond_nxt     = zone_eval;
         chg_nxt      = chg_eval;
         otg_nxt      = otg_eval;
         isel_nxt     = isel_eval;
         vsel_nxt     = vsel_eval;
         hot_lim_nxt  = hot_f;
         cold_lim_nxt = ctrl_a_r[TPC_OTG_COLD_BIT];
         cold_sel_nxt = field3(ctrl_b_r, TPC_COLD_SEL_LSB);
         hot_sel_nxt  = field3(ctrl_b_r, TPC_HOT_SEL_LSB);
      end
   end

   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         THERMISTOR_CONDITION     <= TPC_ZONE_NORMAL;
         CHARGE_ALLOW             <= 1'b0;
         OTG_ALLOW                <= 1'b0;
         CHARGE_CURRENT_SEL       <= TPC_I_FULL;
         CHARGE_VOLTAGE_SEL       <= TPC_V_UNCHANGED;
         OTG_HOT_LIMIT            <= TPC_RST_CTRL_A[TPC_OTG_HOT_LSB +: 2];
         OTG_COLD_LIMIT           <= TPC_RST_CTRL_A[TPC_OTG_COLD_BIT];
         COLD_SIDE_COMPARATOR_SEL <= TPC_RST_CTRL_B[TPC_COLD_SEL_LSB +: 3];
         HOT_SIDE_COMPARATOR_SEL  <= TPC_RST_CTRL_B[TPC_HOT_SEL_LSB +: 3];
      end
      else
      begin
         THERMISTOR_CONDITION     <= cond_nxt;
         CHARGE_ALLOW             <= chg_nxt;
         OTG_ALLOW                <= otg_nxt;
         CHARGE_CURRENT_SEL       <= isel_nxt;
         CHARGE_VOLTAGE_SEL       <= vsel_nxt;
         OTG_HOT_LIMIT            <= hot_lim_nxt;
         OTG_COLD_LIMIT           <= cold_lim_nxt;
         COLD_SIDE_COMPARATOR_SEL <= cold_sel_nxt;
         HOT_SIDE_COMPARATOR_SEL  <= hot_sel_nxt;
      end
   end
endmodule // tpc_regs
`default_nettype wire

/* File: tb/tpc_host.sv */
// host model: drives the register write port of the block
// assumes one rising-edge clock shared with the block
`timescale 1ns/10ps
`default_nettype none
module tpc_host
(
   input  wire logic       CLOCK,
   output logic            WR_EN,
   output logic [7:0]      ADDR,
   output logic [7:0]      WR_DATA
);
   initial
   begin
      WR_EN = 1'b0;
      ADDR = 8'h00;
      WR_DATA = 8'h00;
   end
   // data is inverted on release so nothing leans on a stale bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLOCK);
      WR_EN <= 1'b1;
      ADDR <= a;
      WR_DATA <= d;
      @(posedge CLOCK);
      WR_EN <= 1'b0;
      WR_DATA <= ~d;
   endtask
   task automatic sel(input logic [7:0] a);
      @(posedge CLOCK);
      ADDR <= a;
      @(posedge CLOCK);
   endtask
endmodule // tpc_host
`default_nettype wire

/* File: tb/tpc_regs_props.sv */
// checker for the thermistor profile registers
// assumes it is bound to tpc_regs from the bench
`timescale 1ns/10ps
`default_nettype none
module tpc_regs_props
   import tpc_pkg::*;
#(
   parameter int EVAL_CYCLES = tpc_pkg::TPC_EVAL_CYCLES
)
(
   input wire logic               CLOCK,
   input wire logic               RESET_N,
   input wire logic               REG_RESET,
   input wire logic               WATCHDOG_EXPIRED,
   input wire logic               WR_EN,
   input wire logic [7:0]         ADDR,
   input wire logic [7:0]         WR_DATA,
   input wire logic [7:0]         RD_DATA,
   input wire tpc_pkg::tpc_zone_t THERMISTOR_CONDITION,
   input wire logic               CHARGE_ALLOW,
   input wire logic               OTG_ALLOW,
   input wire logic [1:0]         CHARGE_CURRENT_SEL,
   input wire logic [1:0]         CHARGE_VOLTAGE_SEL
);
   import tpc_pkg::*;

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);
   sequence s_wr_b;
      WR_EN && ADDR == TPC_ADDR_CTRL_B && !REG_RESET;
   endsequence
   a_write_back: assert property (s_wr_b |=> RD_DATA == $past(WR_DATA))
      else $error("readback after write wrong");
   sequence s_wr_a;
      WR_EN && ADDR == TPC_ADDR_CTRL_A && !REG_RESET && !WATCHDOG_EXPIRED;
   endsequence
   a_write_a: assert property (s_wr_a |=> RD_DATA == $past(WR_DATA))
      else $error("ctrl a readback after write wrong");
   a_reset_a: assert property (REG_RESET && ADDR == TPC_ADDR_CTRL_A
      |=> RD_DATA == TPC_RST_CTRL_A) else $error("ctrl a not restored");
   a_reset_b: assert property (REG_RESET && ADDR == TPC_ADDR_CTRL_B
      |=> RD_DATA == TPC_RST_CTRL_B) else $error("ctrl b not restored");
   a_unmapped_zero: assert property (ADDR != TPC_ADDR_CTRL_A && ADDR != TPC_ADDR_CTRL_B
      |=> RD_DATA == 8'h00) else $error("unmapped read not zero");
   a_watchdog_bit: assert property (WATCHDOG_EXPIRED && ADDR == TPC_ADDR_CTRL_A
      |=> !RD_DATA[7]) else $error("override kept after watchdog");
   a_cold_block: assert property (THERMISTOR_CONDITION == TPC_ZONE_COLD
      |-> !CHARGE_ALLOW && !OTG_ALLOW && CHARGE_CURRENT_SEL == TPC_I_SUSPEND)
      else $error("cold zone not blocking");
   a_hot_block: assert property (THERMISTOR_CONDITION == TPC_ZONE_HOT
      |-> !CHARGE_ALLOW && CHARGE_CURRENT_SEL == TPC_I_SUSPEND) else $error("hot zone charging");
   a_cool_charge: assert property (THERMISTOR_CONDITION == TPC_ZONE_COOL
      |-> CHARGE_ALLOW == (CHARGE_CURRENT_SEL != TPC_I_SUSPEND)) else $error("cool allow wrong");
   a_voltage_warm: assert property (THERMISTOR_CONDITION != TPC_ZONE_WARM
      |-> CHARGE_VOLTAGE_SEL == TPC_V_UNCHANGED) else $error("voltage cut outside warm");
   a_zone_holds: assert property ($changed(THERMISTOR_CONDITION)
      |=> $stable(THERMISTOR_CONDITION)[*3]) else $error("zone changed between ticks");
endmodule // tpc_regs_props
`default_nettype wire

/* File: tb/tpc_regs_tb.sv */
// self-checking bench for the thermistor profile registers
// assumes the host model drives writes; the checker is bound at the foot
`timescale 1ns/10ps
`default_nettype none
module tpc_regs_tb;
   import tpc_pkg::*;
   localparam int EV = 4;
   typedef struct {logic [7:0] a; logic [7:0] b; tpc_zone_t z;
                   tpc_zone_t c; logic [1:0] i; logic [1:0] v;} tpc_row_t;
   logic       clock, reset_n, reg_reset, wdog, chg, otg, cold, wr_en;
   logic [7:0] addr, wr_data, rd_data;
   logic [1:0] cur, volt, hot;
   logic [2:0] csel, hsel;
   tpc_zone_t  raw, cond;
   int         n_errors = 0, n_checks = 0, cycles = 0;
   tpc_row_t   rows [10] = '{
      '{8'h00, 8'h00, TPC_ZONE_WARM, TPC_ZONE_WARM, 2'h0, 2'h0},
      '{8'h04, 8'h45, TPC_ZONE_WARM, TPC_ZONE_WARM, 2'h1, 2'h1},
      '{8'h28, 8'hA6, TPC_ZONE_WARM, TPC_ZONE_WARM, 2'h2, 2'h2},
      '{8'h5C, 8'h1F, TPC_ZONE_WARM, TPC_ZONE_WARM, 2'h3, 2'h3},
      '{8'h02, 8'hF3, TPC_ZONE_COOL, TPC_ZONE_COOL, 2'h2, 2'h3},
      '{8'h03, 8'h00, TPC_ZONE_COOL, TPC_ZONE_COOL, 2'h3, 2'h3},
      '{8'h60, 8'h80, TPC_ZONE_HOT, TPC_ZONE_HOT, 2'h0, 2'h3},
      '{8'h20, 8'h00, TPC_ZONE_HOT, TPC_ZONE_HOT, 2'h0, 2'h3},
      '{8'h80, 8'h00, TPC_ZONE_HOT, TPC_ZONE_NORMAL, 2'h3, 2'h3},
      '{8'h10, 8'h00, TPC_ZONE_COLD, TPC_ZONE_COLD, 2'h0, 2'h3}};
   tpc_regs #(.EVAL_CYCLES(EV)) DUT
   (.CLOCK(clock), .RESET_N(reset_n), .REG_RESET(reg_reset), .WATCHDOG_EXPIRED(wdog),
    .WR_EN(wr_en), .ADDR(addr), .WR_DATA(wr_data), .RD_DATA(rd_data), .RAW_ZONE(raw),
    .THERMISTOR_CONDITION(cond), .CHARGE_ALLOW(chg), .OTG_ALLOW(otg),
    .CHARGE_CURRENT_SEL(cur), .CHARGE_VOLTAGE_SEL(volt), .OTG_HOT_LIMIT(hot),
    .OTG_COLD_LIMIT(cold), .COLD_SIDE_COMPARATOR_SEL(csel), .HOT_SIDE_COMPARATOR_SEL(hsel));
   tpc_host host (.CLOCK(clock), .WR_EN(wr_en), .ADDR(addr), .WR_DATA(wr_data));
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic finish_test;
      if (n_errors == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // a hang ends the run as a failure
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_errors++;
         finish_test;
      end
   end
   initial
   begin
      reset_n = 1'b0;
      reg_reset = 1'b0;
      wdog = 1'b0;
      raw = TPC_ZONE_NORMAL;
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      host.sel(TPC_ADDR_CTRL_A);
      #1 chk("ctrl_a", rd_data, TPC_RST_CTRL_A);
      host.sel(TPC_ADDR_CTRL_B);
      #1 chk("ctrl_b", rd_data, TPC_RST_CTRL_B);
      chk("fields", {hot, cold, csel, hsel}, {2'h1, 1'b1, 3'h1, 3'h1});
      foreach (rows[k])
      begin
         host.wr(TPC_ADDR_CTRL_A, rows[k].a);
         host.wr(TPC_ADDR_CTRL_B, rows[k].b);
         raw <= rows[k].z;
         repeat (EV + 2) @(posedge clock);
         #1 chk("zone", cond, rows[k].c);
         chk("current", cur, rows[k].i);
         chk("voltage", volt, rows[k].v);
         chk("charge", chg, rows[k].i != TPC_I_SUSPEND);
         chk("fields", {hot, cold, csel, hsel},
             {rows[k].a[6:4], rows[k].b[7:2]});
         if (rows[k].c == TPC_ZONE_HOT)
            chk("otg", otg, rows[k].a[6:5] == TPC_HOT_DISABLE);
         if (rows[k].c == TPC_ZONE_NORMAL)
            chk("allow", {chg, otg}, 2'h3);
      end
      host.wr(8'h1C, 8'hFF);
      #1 chk("unmapped", rd_data, 8'h00);
      host.wr(TPC_ADDR_CTRL_A, 8'hAA);
      wdog <= 1'b1;
      @(posedge clock);
      wdog <= 1'b0;
      #1 chk("watchdog", rd_data, 8'h2A);
      @(posedge clock);
      reg_reset <= 1'b1;
      host.wr(TPC_ADDR_CTRL_B, 8'h00);
      reg_reset <= 1'b0;
      #1 chk("ctrl_b", rd_data, TPC_RST_CTRL_B);
      host.sel(TPC_ADDR_CTRL_A);
      #1 chk("ctrl_a", rd_data, TPC_RST_CTRL_A);
      host.wr(TPC_ADDR_CTRL_A, 8'h80);
      reset_n <= 1'b0;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      host.sel(TPC_ADDR_CTRL_A);
      #1 chk("power_reset", rd_data, TPC_RST_CTRL_A);
      finish_test;
   end
endmodule // tpc_regs_tb
bind tpc_regs tpc_regs_props #(.EVAL_CYCLES(EVAL_CYCLES)) u_props
   (.CLOCK, .RESET_N, .REG_RESET, .WATCHDOG_EXPIRED, .WR_EN, .ADDR, .WR_DATA, .RD_DATA,
    .THERMISTOR_CONDITION, .CHARGE_ALLOW, .OTG_ALLOW, .CHARGE_CURRENT_SEL, .CHARGE_VOLTAGE_SEL);
`default_nettype wire
